// >>> core/ormg_top.sv
// Purpose: Crossbar mixer with range extender and noise gate
// Assumes: One input sample set per output sample period
// Notes: Outputs 4 and 5 feed the converter channels
`timescale 1ns/1ps
module ormg_top (
	input  wire logic                                  i_mclk,
	input  wire logic                                  i_rst,
	input  wire logic                                  i_src_valid,
	output logic                                       o_src_ready,
	input  wire logic [ormg_pkg::N_SRC-1:0][23:0]      i_src,
	input  wire logic [ormg_pkg::N_OUT-1:0][6:0]       i_src_sel,
	input  wire logic [ormg_pkg::N_OUT-1:0][6:0][4:0]  i_path_gain,
	input  wire logic [1:0]                            i_rext_enable,
	input  wire logic [3:0]                            i_rext_start_level,
	input  wire logic [2:0]                            i_rext_clip_level,
	input  wire logic [3:0]                            i_rext_max_steps,
	input  wire logic [3:0]                            i_rext_fall_coeff,
	input  wire logic [3:0]                            i_rext_rise_coeff,
	input  wire logic                                  i_rext_ramp_en,
	input  wire logic                                  i_rext_fine_en,
	input  wire logic                                  i_gate_enable,
	input  wire logic [2:0]                            i_gate_close_level,
	input  wire logic [2:0]                            i_gate_open_level,
	input  wire logic [1:0]                            i_gate_hold_samples,
	input  wire logic [1:0]                            i_gate_fall_rate,
	input  wire logic [1:0]                            i_gate_rise_rate,
	output logic                                       o_out_valid,
	input  wire logic                                  i_out_ready,
	output logic [ormg_pkg::N_OUT-1:0][23:0]           o_out_data,
	output logic [1:0][5:0]                            o_rext_gain,
	output logic [8:0]                                 o_gate_atten,
	output logic                                       o_gate_muted
);
	localparam int SW = ormg_pkg::SW;
	localparam int NO = ormg_pkg::N_OUT;
	localparam int NS = ormg_pkg::N_SRC;

	ormg_strm_if #(.W(NO*SW)) in_s ();
	ormg_strm_if #(.W(NO*SW)) out_s ();

	function automatic logic [SW-1:0] sat(input logic signed [ormg_pkg::SUMW-1:0] v);
		if (v > ormg_pkg::POS_MAX) return ormg_pkg::POS_MAX[SW-1:0];
		if (v < ormg_pkg::NEG_MIN) return ormg_pkg::NEG_MIN[SW-1:0];
		return v[SW-1:0];
	endfunction : sat

	// Crossbar path gains
	logic signed [ormg_pkg::PW-1:0]   prod [NO][NS];
	logic signed [ormg_pkg::SUMW-1:0] sum  [NO];
	for (genvar o = 0; o < NO; o++) begin : g_out
		for (genvar s = 0; s < NS; s++) begin : g_src
			wire logic signed [ormg_pkg::GW-1:0] st =
				($signed({5'h00, i_path_gain[o][s]}) - ormg_pkg::PATH_UNITY)
				<<< ormg_pkg::SUB_SH;
			ormg_gain #(.IW(SW), .OW(ormg_pkg::PW)) u_path (
				.i_sample ($signed(i_src[s])),
				.i_steps  (st),
				.o_value  (prod[o][s])
			);
		end
	end

	always_comb begin
		for (int o = 0; o < NO; o++) begin
			sum[o] = '0;
			for (int s = 0; s < NS; s++) begin
				if (i_src_sel[o][s]) begin
					sum[o] = sum[o] + ormg_pkg::SUMW'(prod[o][s]);
				end
			end
		end
	end

	// Mixed sample stage
	logic [SW-1:0] mix_q [NO];
	logic          mix_v;
	wire logic acc  = i_src_valid & o_src_ready;
	wire logic tick = mix_v & in_s.ready;
	assign o_src_ready = ~mix_v | in_s.ready;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mix_v <= 1'b0;
			for (int o = 0; o < NO; o++) mix_q[o] <= '0;
		end else begin
			mix_v <= acc | (mix_v & ~tick);
			if (acc) for (int o = 0; o < NO; o++) mix_q[o] <= sat(sum[o]);
		end
	end

	// Level trackers and range extender, one per converter channel
	logic [SW+15:0] avg      [2];
	logic [SW+15:0] next_avg [2];
	logic [3:0]     tgt      [2];
	logic [3:0]     next_tgt [2];
	logic [5:0]     rext_q   [2];
	logic [5:0]     next_rext[2];
	logic [1:0]     low;
	logic [1:0]     clip;
	logic [1:0]     below;
	logic [1:0]     above;
	logic [8:0]     gate_q;
	logic [SW-1:0]  fin      [2];
	ormg_pkg::ormg_gate_t gstate;

	wire logic [3:0] rise_sh = (i_rext_rise_coeff > 4'(ormg_pkg::RISE_SH_MAX))
		? 4'(ormg_pkg::RISE_SH_MAX) : i_rext_rise_coeff;
	wire logic [4:0] fall_sum = 5'(ormg_pkg::FALL_SH_MIN) + {1'b0, i_rext_fall_coeff};
	wire logic [4:0] fall_sh = (fall_sum > 5'(ormg_pkg::FALL_SH_MAX))
		? 5'(ormg_pkg::FALL_SH_MAX) : fall_sum;
	wire logic [6:0] sub_step = i_rext_fine_en ? 7'h01 : 7'h04;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		wire logic [SW-1:0] smp = mix_q[ormg_pkg::FILT_BASE + c];
		wire logic [SW-1:0] mag = smp[SW-1] ? SW'(-smp) : smp;
		wire logic [SW+15:0] x40 = {mag, 16'h0000};
		wire logic [SW-1:0] lvl = avg[c][SW+15:ormg_pkg::AVG_FRAC];
		assign next_avg[c] = (x40 > avg[c]) ? avg[c] + ((x40 - avg[c]) >> rise_sh)
			: avg[c] - ((avg[c] - x40) >> fall_sh);
		assign low[c]   = lvl < (24'h000001 << (ormg_pkg::START_BASE
			+ int'(i_rext_start_level)));
		assign clip[c]  = lvl >= (24'h000001 << (ormg_pkg::CLIP_BASE
			+ int'(i_rext_clip_level)));
		assign below[c] = lvl < (24'h000001 << (ormg_pkg::GATE_BASE
			+ int'(i_gate_close_level)));
		assign above[c] = lvl > (24'h000001 << (ormg_pkg::GATE_BASE
			+ int'(i_gate_open_level)));
		assign next_tgt[c] = clip[c] ? 4'h0 : (low[c] ? i_rext_max_steps : tgt[c]);
		wire logic [6:0] goal = {1'b0, next_tgt[c], 2'b00};
		wire logic [6:0] cur  = {1'b0, rext_q[c]};
		wire logic [6:0] ramp = (cur < goal) ? ((cur + sub_step < goal) ? cur + sub_step : goal)
			: ((cur > goal + sub_step) ? cur - sub_step : goal);
		assign next_rext[c] = !i_rext_enable[c] ? 6'h00
			: (i_rext_ramp_en ? ramp[5:0] : goal[5:0]);
		wire logic signed [ormg_pkg::GW-1:0] fstep =
			$signed({4'h0, rext_q[c]}) - $signed({1'b0, gate_q});
		logic signed [ormg_pkg::PW-1:0] fval;
		ormg_gain #(.IW(SW), .OW(ormg_pkg::PW)) u_fin (
			.i_sample ($signed(smp)),
			.i_steps  (fstep),
			.o_value  (fval)
		);
		assign fin[c] = (gstate == ormg_pkg::G_MUTED) ? '0
			: sat(ormg_pkg::SUMW'(fval));
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			for (int c = 0; c < 2; c++) begin
				avg[c]    <= '0;
				tgt[c]    <= '0;
				rext_q[c] <= '0;
			end
		end else if (tick) begin
			for (int c = 0; c < 2; c++) begin
				avg[c]    <= next_avg[c];
				tgt[c]    <= next_tgt[c];
				rext_q[c] <= next_rext[c];
			end
		end
	end

	// Noise gate
	ormg_pkg::ormg_gate_t next_gstate;
	logic [11:0] hold_cnt;
	logic [11:0] next_hold;
	logic [8:0]  next_gate_q;
	wire logic [11:0] hold_lim  = ormg_pkg::HOLD_BASE << i_gate_hold_samples;
	wire logic [8:0]  fall_step = 9'h001 << i_gate_fall_rate;
	wire logic [8:0]  rise_step = 9'h001 << i_gate_rise_rate;
	wire logic        all_below = &below;
	wire logic        any_above = |above;
	wire logic        gate_off  = ~i_gate_enable | any_above;

	always_comb begin
		next_gstate = gstate;
		next_gate_q = gate_q;
		next_hold   = hold_cnt;
		case (gstate)
			ormg_pkg::G_OPEN: begin
				if (i_gate_enable && all_below) begin
					next_hold = hold_cnt + 12'h001;
					if (hold_cnt == hold_lim - 12'h001) begin
						next_gstate = ormg_pkg::G_FALL;
						next_hold   = '0;
					end
				end else begin
					next_hold = '0;
				end
			end
			ormg_pkg::G_FALL: begin
				if (gate_off) begin
					next_gstate = ormg_pkg::G_RISE;
				end else if (gate_q >= ormg_pkg::GATE_MAX - fall_step) begin
					next_gate_q = ormg_pkg::GATE_MAX;
					next_gstate = ormg_pkg::G_MUTED;
				end else begin
					next_gate_q = gate_q + fall_step;
				end
			end
			ormg_pkg::G_MUTED: begin
				if (gate_off) next_gstate = ormg_pkg::G_RISE;
			end
			ormg_pkg::G_RISE: begin
				if (gate_q <= rise_step) begin
					next_gate_q = '0;
					next_gstate = ormg_pkg::G_OPEN;
				end else begin
					next_gate_q = gate_q - rise_step;
				end
			end
			default: next_gstate = ormg_pkg::G_OPEN;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			gstate   <= ormg_pkg::G_OPEN;
			gate_q   <= '0;
			hold_cnt <= '0;
		end else if (tick) begin
			gstate   <= next_gstate;
			gate_q   <= next_gate_q;
			hold_cnt <= next_hold;
		end
	end

	// Output buffer
	logic [NO-1:0][SW-1:0] push;
	always_comb begin
		for (int o = 0; o < NO; o++) push[o] = mix_q[o];
		push[ormg_pkg::FILT_BASE]     = fin[0];
		push[ormg_pkg::FILT_BASE + 1] = fin[1];
	end
	assign in_s.valid  = mix_v;
	assign in_s.data   = push;
	assign out_s.ready = i_out_ready;
	assign o_out_valid = out_s.valid;
	assign o_out_data  = out_s.data;
	assign o_rext_gain = {rext_q[1], rext_q[0]};
	assign o_gate_atten = gate_q;
	assign o_gate_muted = (gstate == ormg_pkg::G_MUTED);

	ormg_buf #(.W(NO*SW), .DEPTH(2)) u_buf (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.s_in   (in_s),
		.s_out  (out_s)
	);

	// Checks
	property p_no_source;
		@(posedge i_mclk) disable iff (i_rst)
		(acc && i_src_sel[0] == '0) |=> (mix_q[0] == '0);
	endproperty
	a_no_source: assert property (p_no_source) else $error("unrouted output not zero");
	property p_start_level;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && low[0] && !clip[0]) |=> (tgt[0] == $past(i_rext_max_steps));
	endproperty
	a_start_level: assert property (p_start_level) else $error("target not max");
	property p_clip;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && clip[1]) |=> (tgt[1] == 4'h0);
	endproperty
	a_clip: assert property (p_clip) else $error("clip did not drop target");
	property p_no_ramp;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && !i_rext_ramp_en && i_rext_enable[0]) |=> (rext_q[0] == {tgt[0], 2'b00});
	endproperty
	a_no_ramp: assert property (p_no_ramp) else $error("gain did not jump");
	property p_fine;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && i_rext_ramp_en && i_rext_fine_en && i_rext_enable[0])
		|=> (rext_q[0] - $past(rext_q[0]) inside {6'h00, 6'h01, 6'h3f});
	endproperty
	a_fine: assert property (p_fine) else $error("sub-step too large");
	property p_chan_off;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && !i_rext_enable[1]) |=> (rext_q[1] == 6'h00);
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("disabled channel has gain");
	property p_open_fast;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && gstate == ormg_pkg::G_MUTED && any_above)
		|=> (gstate == ormg_pkg::G_RISE) ##1 (gate_q < ormg_pkg::GATE_MAX || !$past(tick));
	endproperty
	a_open_fast: assert property (p_open_fast) else $error("gate did not open");
	property p_hold;
		@(posedge i_mclk) disable iff (i_rst)
		(tick && gstate == ormg_pkg::G_OPEN && next_gstate == ormg_pkg::G_FALL)
		|-> (all_below && i_gate_enable && hold_cnt == hold_lim - 12'h001);
	endproperty
	a_hold: assert property (p_hold) else $error("gate closed early");
	property p_muted_min;
		@(posedge i_mclk) disable iff (i_rst)
		(gstate == ormg_pkg::G_MUTED) |-> (gate_q == ormg_pkg::GATE_MAX && fin[0] == '0);
	endproperty
	a_muted_min: assert property (p_muted_min) else $error("muted above minimum");
	property p_per_sample;
		@(posedge i_mclk) disable iff (i_rst)
		!tick |=> ($stable(avg[0]) && $stable(gate_q));
	endproperty
	a_per_sample: assert property (p_per_sample) else $error("tracker moved off tick");
endmodule : ormg_top

// >>> inc/ormg_pkg.sv
// Purpose: Shared constants and types of the output mixer block
// Assumes: 24-bit two's complement samples, one clock i_mclk
// Notes: Gain units are 0.375 dB, four to each 1.5 dB step
//
// Functional notes
// - Range extender enabled per output channel
// - Start level -90..0 dB, 6 dB steps
// - Above clip level, remove all gain steps
// - Gain in 1.5 dB units, capped
// - Tracker falls by programmable 1/65536..1/4
// - Tracker rises by programmable 1/16384..1
// - Ramp enable moves one step per sample
// - Fine step splits each step further
// - Gate mutes after both levels stay low
// - Close threshold -102..-60 dB, 6 dB steps
// - Open threshold same range, own field
// - Hold 256, 512, 1024 or 2048 samples
// - Gate opens at once above open level
// - Gate ramps down, then up, own rates
// - Any inputs to any outputs, 42 gains
// - Select bits: filters, tone, serial inputs
// - Select bit 0 disables, 1 enables path
// - Path gain -42..+4.5 dB, 1.5 dB steps
// - Code 00000 is -42 dB, 11100 unity
package ormg_pkg;
	localparam int N_SRC     = 7;
	localparam int N_OUT     = 6;
	localparam int SW        = 24;
	localparam int CW        = 5;
	localparam int GW        = 10;
	localparam int PW        = 30;
	localparam int SUMW      = 34;
	localparam int SUB_SH    = 2;
	localparam int MANT_FRAC = 14;
	localparam int FILT_BASE = 4;
	localparam int AVG_FRAC  = 16;
	localparam int START_BASE  = 8;
	localparam int CLIP_BASE   = 16;
	localparam int GATE_BASE   = 6;
	localparam int FALL_SH_MIN = 2;
	localparam int FALL_SH_MAX = 16;
	localparam int RISE_SH_MAX = 14;
	localparam logic signed [GW-1:0]   PATH_UNITY = 10'sh01c;
	localparam logic [11:0]            HOLD_BASE  = 12'h100;
	localparam logic [8:0]             GATE_MAX   = 9'h100;
	localparam logic signed [SUMW-1:0] POS_MAX    = 34'sh0007fffff;
	localparam logic signed [SUMW-1:0] NEG_MIN    = 34'sh3ff800000;
	localparam logic [15:0] GAIN_MANT [16] = '{
		16'h4000, 16'h42d5, 16'h45cb, 16'h48e2, 16'h4c1c, 16'h4f7b, 16'h52ff, 16'h56ac,
		16'h5a82, 16'h5e84, 16'h62b4, 16'h6712, 16'h6ba2, 16'h7066, 16'h7560, 16'h7a93};
	typedef enum logic [1:0] {G_OPEN, G_FALL, G_MUTED, G_RISE} ormg_gate_t;
endpackage : ormg_pkg

// >>> inc/ormg_strm_if.sv
// Purpose: Valid/ready word stream between block modules
// Assumes: Word taken when valid and ready are both high
// Notes: None
`timescale 1ns/1ps
interface ormg_strm_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : ormg_strm_if

// >>> core/ormg_gain.sv
// Purpose: Multiply a sample by a gain given in 0.375 dB units
// Assumes: Step range keeps the result within OW bits
// Notes: Sixteen mantissas per octave, then a power-of-two shift
`timescale 1ns/1ps
module ormg_gain #(
	parameter int IW = 24,
	parameter int OW = 30
) (
	input  wire logic signed [IW-1:0]           i_sample,
	input  wire logic signed [ormg_pkg::GW-1:0] i_steps,
	output logic signed [OW-1:0]                o_value
);
	wire logic signed [5:0]    gexp    = i_steps[ormg_pkg::GW-1:4];
	wire logic [15:0]          mant    = ormg_pkg::GAIN_MANT[i_steps[3:0]];
	wire logic signed [IW+16:0] prod   = i_sample * $signed({1'b0, mant});
	wire logic signed [IW+16:0] scaled = prod >>> ormg_pkg::MANT_FRAC;
	wire logic [5:0]           neg_exp = 6'(-gexp);
	wire logic signed [IW+16:0] shifted = gexp[5] ? (scaled >>> neg_exp)
		: (scaled <<< gexp[4:0]);
	assign o_value = shifted[OW-1:0];
endmodule : ormg_gain

// >>> core/ormg_buf.sv
// Purpose: Two-entry stream buffer between mixer and receiver
// Assumes: Receiver may stall at any time
// Notes: Ready to the filling side is a true not-full
`timescale 1ns/1ps
module ormg_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic  i_mclk,
	input  wire logic  i_rst,
	ormg_strm_if.snk   s_in,
	ormg_strm_if.src   s_out
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	wire logic push = s_in.valid & s_in.ready;
	wire logic pop  = s_out.valid & s_out.ready;
	assign s_in.ready  = (cnt != (AW+1)'(DEPTH));
	assign s_out.valid = (cnt != '0);
	assign s_out.data  = mem[rp];

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
			for (int k = 0; k < DEPTH; k++) mem[k] <= '0;
		end else begin
			if (push) mem[wp] <= s_in.data;
			if (push) wp <= AW'((wp == AW'(DEPTH - 1)) ? 0 : wp + 1'b1);
			if (pop) rp <= AW'((rp == AW'(DEPTH - 1)) ? 0 : rp + 1'b1);
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ormg_buf

// >>> verif/ormg_src_model.sv
// Purpose: Source side model: input filters, tone and serial inputs
// Assumes: Sets queued by the bench, one set per handshake
// Notes: Data lines change every cycle while no set is offered
`timescale 1ns/1ps
module ormg_src_model (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_ready,
	output logic             o_valid,
	output logic [6:0][23:0] o_src
);
	logic [6:0][23:0] q[$];
	initial begin
		o_valid = 1'b0;
		o_src   = '0;
	end
	task automatic push(input logic [6:0][23:0] s);
		q.push_back(s);
	endtask : push
	// Hold a set until taken, then offer the next
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_src   <= ~o_src;
		end else if (!o_valid || i_ready) begin
			if (q.size() != 0) begin
				o_valid <= 1'b1;
				o_src   <= q.pop_front();
			end else begin
				o_valid <= 1'b0;
				o_src   <= ~o_src;
			end
		end
	end
endmodule : ormg_src_model

// >>> verif/ormg_top_tb_top.sv
// Purpose: Self-checking bench for the output mixer block
// Assumes: Outputs 4 and 5 compared only with extender and gate idle
// Notes: Path codes 20, 24 and 28 keep every gain an exact shift
`timescale 1ns/1ps
module ormg_top_tb_top;
	typedef struct {
		logic [5:0][23:0] d;
		logic [5:0]       m;
	} ormg_note_t;
	logic                 mclk = 1'b0, rst = 1'b1, out_ready = 1'b1;
	logic                 ramp = 1'b0, fine = 1'b0, g_en = 1'b0;
	logic                 src_valid, src_ready, out_valid, muted;
	logic [6:0][23:0]     src;
	logic [5:0][6:0]      sel = '0;
	logic [5:0][6:0][4:0] pg = {42{5'h1c}};
	logic [5:0][23:0]     out_data;
	logic [1:0][5:0]      rgain;
	logic [8:0]           atten;
	logic [1:0]           rx_en = 2'h0, hold = 2'h0, g_fall = 2'h3, g_rise = 2'h3;
	logic [3:0]           rx_start = 4'hf, rx_steps = 4'h5, rx_fall = 4'h0, rx_rise = 4'h0;
	logic [2:0]           rx_clip = 3'h7, g_close = 3'h3, g_open = 3'h5;
	logic [15:0]          rnd = 16'hb86d, rr = 16'hb86d;
	int                   rmode, n_errors, tests_run;
	ormg_note_t           exp_q[$];
	ormg_top ormg_top_i (
		.i_mclk(mclk), .i_rst(rst), .i_src_valid(src_valid), .o_src_ready(src_ready),
		.i_src(src), .i_src_sel(sel), .i_path_gain(pg), .i_rext_enable(rx_en),
		.i_rext_start_level(rx_start), .i_rext_clip_level(rx_clip),
		.i_rext_max_steps(rx_steps), .i_rext_fall_coeff(rx_fall),
		.i_rext_rise_coeff(rx_rise), .i_rext_ramp_en(ramp), .i_rext_fine_en(fine),
		.i_gate_enable(g_en), .i_gate_close_level(g_close), .i_gate_open_level(g_open),
		.i_gate_hold_samples(hold), .i_gate_fall_rate(g_fall), .i_gate_rise_rate(g_rise),
		.o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_data(out_data),
		.o_rext_gain(rgain), .o_gate_atten(atten), .o_gate_muted(muted)
	);
	ormg_src_model ormg_src_model_i (
		.i_mclk(mclk), .i_rst(rst), .i_ready(src_ready), .o_valid(src_valid), .o_src(src)
	);
	always #12.5 mclk = ~mclk;
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic [6:0][23:0] rset();
		logic [6:0][23:0] s;
		for (int i = 0; i < 7; i++) begin
			rnd = lfsr(rnd);
			s[i][23:8] = rnd;
			rnd = lfsr(rnd);
			s[i][7:0] = rnd[7:0] & 8'hfc;
		end
		return s;
	endfunction : rset
	function automatic logic [23:0] mix(input logic [6:0][23:0] s, input logic [6:0] e,
		input logic [6:0][4:0] g);
		logic signed [33:0] acc;
		acc = '0;
		for (int i = 0; i < 7; i++)
			if (e[i])
				acc += $signed(s[i]) >>> ((5'd28 - g[i]) >> 2);
		if (acc > ormg_pkg::POS_MAX)
			return 24'h7fffff;
		if (acc < ormg_pkg::NEG_MIN)
			return 24'h800000;
		return acc[23:0];
	endfunction : mix
	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic send(input logic [6:0][23:0] s, input logic [5:0] m, input int n = 1);
		ormg_note_t w;
		for (int k = 0; k < 6; k++)
			w.d[k] = mix(s, sel[k], pg[k]);
		w.m = m;
		repeat (n) begin
			exp_q.push_back(w);
			ormg_src_model_i.push(s);
		end
	endtask : send
	task automatic drain();
		int t;
		t = 0;
		while ((exp_q.size() != 0 || src_valid !== 1'b0) && t < 8000) begin
			@(posedge mclk);
			t++;
		end
		if (t >= 8000) begin
			n_errors++;
			$display("mismatch drain expected %0d seen %0d", 0, exp_q.size());
			tally_and_finish();
		end
		repeat (3) @(posedge mclk);
		#1;
	endtask : drain
	task automatic idle_chk();
		chk("src_ready", 24'(src_ready), 24'h1);
		chk("out_valid", 24'(out_valid), 24'h0);
		chk("rgain", 24'(rgain), 24'h0);
		chk("atten", 24'(atten), 24'h0);
		chk("muted", 24'(muted), 24'h0);
	endtask : idle_chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Receiver: always ready, random stalls, or fully stalled
	always @(posedge mclk) begin
		rr = lfsr(rr);
		out_ready <= (rmode == 0) || (rmode == 1 && rr[0]);
	end
	// Compare each taken word with the oldest note
	always @(posedge mclk) begin : mon
		ormg_note_t w;
		if (rst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("mismatch out_word expected none seen %h", out_data);
			end else begin
				w = exp_q.pop_front();
				for (int k = 0; k < 6; k++)
					if (w.m[k])
						chk("out_data", out_data[k], w.d[k]);
			end
		end
	end
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rmode <= 1;
		@(posedge mclk);
		#1;
		idle_chk();
		// Single-source sweep, empty routing, then random routing
		for (int b = 0; b < 16; b++) begin
			@(posedge mclk);
			for (int k = 0; k < 6; k++) begin
				rnd = lfsr(rnd);
				sel[k] <= (b < 7) ? 7'(1 << b) : (b == 7) ? 7'h00 : rnd[6:0];
				for (int i = 0; i < 7; i++) begin
					rnd = lfsr(rnd);
					pg[k][i] <= 5'd28 - 5'(4 * (rnd % 3));
				end
			end
			@(posedge mclk);
			send(rset(), 6'h3f, 1);
			for (int j = 0; j < 9; j++)
				send(rset(), 6'h3f);
			drain();
		end
		// Saturation and a full buffer under a stalled receiver
		@(posedge mclk);
		sel <= {6{7'h7f}};
		pg <= {42{5'h1c}};
		rmode <= 2;
		@(posedge mclk);
		send({7{24'h7ffffc}}, 6'h3f);
		send({7{24'h800000}}, 6'h3f);
		send(rset(), 6'h3f, 2);
		repeat (10) @(posedge mclk);
		#1;
		chk("src_ready", 24'(src_ready), 24'h0);
		chk("out_valid", 24'(out_valid), 24'h1);
		rmode <= 0;
		drain();
		// Range extender
		@(posedge mclk);
		sel <= {7'h01, 7'h01, 28'h0};
		rx_en <= 2'b01;
		@(posedge mclk);
		send('0, 6'h0f, 4);
		drain();
		chk("rgain_l", 24'(rgain[0]), 24'd20);
		chk("rgain_r", 24'(rgain[1]), 24'd0);
		@(posedge mclk);
		rx_en <= 2'b11;
		ramp <= 1'b1;
		@(posedge mclk);
		send('0, 6'h0f);
		drain();
		chk("rgain_r", 24'(rgain[1]), 24'd4);
		@(posedge mclk);
		fine <= 1'b1;
		@(posedge mclk);
		send('0, 6'h0f);
		drain();
		chk("rgain_r", 24'(rgain[1]), 24'd5);
		@(posedge mclk);
		ramp <= 1'b0;
		rx_clip <= 3'h6;
		@(posedge mclk);
		send({{6{24'h0}}, 24'h7ffffc}, 6'h0f, 3);
		drain();
		chk("rgain_l", 24'(rgain[0]), 24'd0);
		chk("rgain_r", 24'(rgain[1]), 24'd0);
		// Second reset, then the noise gate
		@(posedge mclk);
		rx_en <= 2'b00;
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		g_en <= 1'b1;
		@(posedge mclk);
		#1;
		idle_chk();
		send('0, 6'h0f, 250);
		drain();
		chk("muted", 24'(muted), 24'h0);
		chk("atten", 24'(atten), 24'h0);
		send('0, 6'h0f, 46);
		drain();
		chk("muted", 24'(muted), 24'h1);
		chk("atten", 24'(atten), 24'h100);
		@(posedge mclk);
		sel <= {7'h00, 7'h01, 28'h0};
		@(posedge mclk);
		send({{6{24'h0}}, 24'h100000}, 6'h0f, 2);
		drain();
		chk("muted", 24'(muted), 24'h0);
		send({{6{24'h0}}, 24'h100000}, 6'h0f, 300);
		drain();
		chk("muted", 24'(muted), 24'h0);
		chk("atten", 24'(atten), 24'h0);
		tally_and_finish();
	end
endmodule : ormg_top_tb_top
